// *** pkg/sbt_pkg.sv ***
// Constants and types shared by the boundary-scan access port.
package sbt_pkg;

   localparam int IR_LEN = 3;
   localparam int BSR_LEN = 109;
   localparam int RING_LEN = 108;
   localparam int BSR_CTRL_BIT = 108;
   localparam int ID_LEN = 32;

   localparam logic [2:0] IR_EXTEST = 3'h0;
   localparam logic [2:0] IR_IDCODE = 3'h1;
   localparam logic [2:0] IR_SAMPLEZ = 3'h2;
   localparam logic [2:0] IR_PRELOAD = 3'h4;
   localparam logic [2:0] IR_BYPASS = 3'h7;
   localparam logic [2:0] IR_RESET = IR_IDCODE;
   // Fixed pattern loaded into the instruction shifter at Capture-IR.
   localparam logic [2:0] IR_CAPTURE = 3'h1;

   // Identification fields; the values below are arbitrary.
   localparam int ID_REV_LSB = 29;
   localparam int ID_PART_LSB = 12;
   localparam int ID_VENDOR_LSB = 1;
   localparam logic [2:0] ID_REV = 3'h2;
   localparam logic [16:0] ID_PART = 17'h0a5a5;
   localparam logic [10:0] ID_VENDOR = 11'h2aa;
   localparam logic [31:0] ID_VALUE = {ID_REV, ID_PART, ID_VENDOR, 1'b1};

   localparam logic CTRL_CELL_RESET = 1'b1;
   localparam logic BYPASS_CAPTURE = 1'b0;

   typedef enum logic [3:0] {
      ST_TLR = 4'h0,
      ST_IDLE = 4'h1,
      ST_SEL_DR = 4'h2,
      ST_CAP_DR = 4'h3,
      ST_SHIFT_DR = 4'h4,
      ST_EXIT1_DR = 4'h5,
      ST_PAUSE_DR = 4'h6,
      ST_EXIT2_DR = 4'h7,
      ST_UPD_DR = 4'h8,
      ST_SEL_IR = 4'h9,
      ST_CAP_IR = 4'ha,
      ST_SHIFT_IR = 4'hb,
      ST_EXIT1_IR = 4'hc,
      ST_PAUSE_IR = 4'hd,
      ST_EXIT2_IR = 4'he,
      ST_UPD_IR = 4'hf
   } sbt_tap_state_type;

endpackage : sbt_pkg

// *** design/sbt_tap_ctrl.sv ***
// Sixteen-state test controller stepped by sampled rising edges of the test clock.
`timescale 1ns/1ps
`default_nettype none
module sbt_tap_ctrl
   import sbt_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic tck_rise_i,
   input wire logic tms_i,
   output sbt_tap_state_type state_o
);

   typedef struct packed {
      sbt_tap_state_type st;
   } sbt_ctrl_type;

   sbt_ctrl_type r;
   sbt_ctrl_type r_nxt;

   always_comb begin
      r_nxt = r;
      if (tck_rise_i) begin
         case (r.st)
            ST_TLR: r_nxt.st = tms_i ? ST_TLR : ST_IDLE;
            ST_IDLE: r_nxt.st = tms_i ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: r_nxt.st = tms_i ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: r_nxt.st = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: r_nxt.st = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: r_nxt.st = tms_i ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: r_nxt.st = tms_i ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: r_nxt.st = tms_i ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: r_nxt.st = tms_i ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: r_nxt.st = tms_i ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: r_nxt.st = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: r_nxt.st = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: r_nxt.st = tms_i ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: r_nxt.st = tms_i ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: r_nxt.st = tms_i ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: r_nxt.st = tms_i ? ST_SEL_DR : ST_IDLE;
            default: r_nxt.st = ST_TLR;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         r <= '{st: ST_TLR};
      end else begin
         r <= r_nxt;
      end
   end

   assign state_o = r.st;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);

   a_tms_high_reset: assert property ((tck_rise_i && tms_i && r.st == ST_SEL_IR) |=> r.st == ST_TLR)
      else $error("Select-IR with mode high did not enter test-logic-reset");
   a_state_hold: assert property (!tck_rise_i |=> $stable(r.st))
      else $error("Controller moved without a test clock rise");

endmodule : sbt_tap_ctrl
`default_nettype wire

// *** design/sbt_tap.sv ***
// Boundary-scan access port: sampled test pins, instruction and data registers, output control.
`timescale 1ns/1ps
`default_nettype none
module sbt_tap
   import sbt_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic tck_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   output logic tdo_o,
   output logic tdo_oe_n_o,
   input wire logic [RING_LEN-1:0] ring_in_i,
   output logic [RING_LEN-1:0] ring_out_o,
   output logic extest_o,
   output logic q_oe_n_o
);

   typedef struct packed {
      logic tck_s1;
      logic tck_s2;
      logic tck_s3;
      logic tms_s1;
      logic tms_s2;
      logic tdi_s1;
      logic tdi_s2;
      logic [RING_LEN-1:0] ring_s1;
      logic [RING_LEN-1:0] ring_s2;
      logic [IR_LEN-1:0] ir;
      logic [IR_LEN-1:0] ir_sh;
      logic [BSR_LEN-1:0] bsr_sh;
      logic [BSR_LEN-1:0] bsr_upd;
      logic [ID_LEN-1:0] id_sh;
      logic byp;
      logic tdo;
      logic tdo_oe_n;
      logic extest;
      logic q_oe_n;
   } sbt_tap_type;

   sbt_tap_type r;
   sbt_tap_type r_nxt;
   sbt_tap_state_type st;
   logic tck_rise;
   logic tck_fall;

   // Reserved codes fall through to the bypass path, which keeps the chain length defined.
   function automatic logic sel_bsr(input logic [IR_LEN-1:0] ir);
      sel_bsr = (ir == IR_EXTEST) || (ir == IR_SAMPLEZ) || (ir == IR_PRELOAD);
   endfunction : sel_bsr

   function automatic logic sel_id(input logic [IR_LEN-1:0] ir);
      sel_id = (ir == IR_IDCODE);
   endfunction : sel_id

   assign tck_rise = r.tck_s2 && !r.tck_s3;
   assign tck_fall = !r.tck_s2 && r.tck_s3;

   sbt_tap_ctrl u_ctrl (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .tck_rise_i(tck_rise),
      .tms_i(r.tms_s2),
      .state_o(st)
   );

   always_comb begin
      r_nxt = r;
      r_nxt.tck_s1 = tck_i;
      r_nxt.tck_s2 = r.tck_s1;
      r_nxt.tck_s3 = r.tck_s2;
      r_nxt.tms_s1 = tms_i;
      r_nxt.tms_s2 = r.tms_s1;
      r_nxt.tdi_s1 = tdi_i;
      r_nxt.tdi_s2 = r.tdi_s1;
      // The ring is sampled continuously; values in transition at capture are not guaranteed.
      r_nxt.ring_s1 = ring_in_i;
      r_nxt.ring_s2 = r.ring_s1;

      if (tck_rise) begin
         case (st)
            ST_CAP_IR: r_nxt.ir_sh = IR_CAPTURE;
            ST_SHIFT_IR: r_nxt.ir_sh = {r.tdi_s2, r.ir_sh[IR_LEN-1:1]};
            ST_CAP_DR: begin
               if (sel_bsr(r.ir)) begin
                  r_nxt.bsr_sh = {r.bsr_upd[BSR_CTRL_BIT], r.ring_s2};
               end else if (sel_id(r.ir)) begin
                  r_nxt.id_sh = ID_VALUE;
               end else begin
                  r_nxt.byp = BYPASS_CAPTURE;
               end
            end
            ST_SHIFT_DR: begin
               if (sel_bsr(r.ir)) begin
                  r_nxt.bsr_sh = {r.tdi_s2, r.bsr_sh[BSR_LEN-1:1]};
               end else if (sel_id(r.ir)) begin
                  r_nxt.id_sh = {r.tdi_s2, r.id_sh[ID_LEN-1:1]};
               end else begin
                  r_nxt.byp = r.tdi_s2;
               end
            end
            default: begin
            end
         endcase
      end

      // Updates and the serial output act on the falling edge, half a test cycle after shifting.
      if (tck_fall) begin
         r_nxt.tdo_oe_n = 1'b1;
         case (st)
            ST_SHIFT_IR: begin
               r_nxt.tdo = r.ir_sh[0];
               r_nxt.tdo_oe_n = 1'b0;
            end
            ST_SHIFT_DR: begin
               r_nxt.tdo_oe_n = 1'b0;
               if (sel_bsr(r.ir)) begin
                  r_nxt.tdo = r.bsr_sh[0];
               end else if (sel_id(r.ir)) begin
                  r_nxt.tdo = r.id_sh[0];
               end else begin
                  r_nxt.tdo = r.byp;
               end
            end
            ST_UPD_IR: r_nxt.ir = r.ir_sh;
            ST_UPD_DR: begin
               if (sel_bsr(r.ir)) begin
                  r_nxt.bsr_upd = r.bsr_sh;
               end
            end
            default: begin
            end
         endcase
      end

      if (st == ST_TLR) begin
         r_nxt.ir = IR_RESET;
         r_nxt.bsr_upd[BSR_CTRL_BIT] = CTRL_CELL_RESET;
      end

      r_nxt.extest = (r.ir == IR_EXTEST);
      if (r.ir == IR_EXTEST) begin
         r_nxt.q_oe_n = !r.bsr_upd[BSR_CTRL_BIT];
      end else if (r.ir == IR_SAMPLEZ) begin
         r_nxt.q_oe_n = 1'b1;
      end else begin
         r_nxt.q_oe_n = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         r <= '0;
         r.ir <= IR_RESET;
         r.ir_sh <= IR_CAPTURE;
         r.bsr_upd[BSR_CTRL_BIT] <= CTRL_CELL_RESET;
         r.tdo_oe_n <= 1'b1;
      end else begin
         r <= r_nxt;
      end
   end

   assign tdo_o = r.tdo;
   assign tdo_oe_n_o = r.tdo_oe_n;
   assign ring_out_o = r.bsr_upd[RING_LEN-1:0];
   assign extest_o = r.extest;
   assign q_oe_n_o = r.q_oe_n;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);

   sequence s_cap_dr;
      tck_rise && st == ST_CAP_DR;
   endsequence

   sequence s_shift_dr;
      tck_rise && st == ST_SHIFT_DR;
   endsequence

   a_tlr_idcode: assert property ((st == ST_TLR) |=> r.ir == IR_IDCODE)
      else $error("Instruction is not identification after test-logic-reset");
   a_tlr_cell_preset: assert property ((st == ST_TLR) |=> r.bsr_upd[BSR_CTRL_BIT])
      else $error("Control cell not preset in test-logic-reset");
   a_id_capture: assert property ((s_cap_dr and sel_id(r.ir)) |=> r.id_sh == ID_VALUE)
      else $error("Identification value not captured");
   a_id_layout: assert property ((s_cap_dr and sel_id(r.ir)) |=> r.id_sh[0] &&
      r.id_sh[ID_LEN-1:ID_REV_LSB] == ID_REV && r.id_sh[ID_REV_LSB-1:ID_PART_LSB] == ID_PART &&
      r.id_sh[ID_PART_LSB-1:ID_VENDOR_LSB] == ID_VENDOR)
      else $error("Identification fields not at their positions");
   a_id_shift: assert property ((s_shift_dr and sel_id(r.ir)) |=>
      r.id_sh == {$past(r.tdi_s2), $past(r.id_sh[ID_LEN-1:1])})
      else $error("Identification register did not shift toward bit zero");
   a_bsr_capture: assert property ((s_cap_dr and sel_bsr(r.ir)) |=>
      r.bsr_sh[RING_LEN-1:0] == $past(r.ring_s2))
      else $error("Ring state not captured into scan chain");
   a_bypass_path: assert property ((s_shift_dr and r.ir == IR_BYPASS) |=> r.byp == $past(r.tdi_s2))
      else $error("Bypass stage did not take serial input");
   a_bsr_lsb_out: assert property ((tck_fall && st == ST_SHIFT_DR && sel_bsr(r.ir)) |=>
      tdo_o == $past(r.bsr_sh[0]) && !tdo_oe_n_o)
      else $error("Scan chain bit zero not presented on falling edge");
   a_samplez_float: assert property ((r.ir == IR_SAMPLEZ) |=> q_oe_n_o)
      else $error("Outputs not floated under sample-float");
   a_samplez_hold: assert property ((r.ir == IR_SAMPLEZ && !(tck_fall && st == ST_UPD_IR) && st != ST_TLR) |=>
      r.ir == IR_SAMPLEZ)
      else $error("Sample-float left without an instruction update");
   a_extest_cell: assert property ((r.ir == IR_EXTEST) |=>
      q_oe_n_o == !$past(r.bsr_upd[BSR_CTRL_BIT]) && extest_o)
      else $error("Control cell does not steer outputs under external test");
   a_normal_drive: assert property ((r.ir == IR_PRELOAD || r.ir == IR_BYPASS || r.ir == IR_IDCODE) |=>
      !q_oe_n_o && !extest_o)
      else $error("Memory outputs disturbed by a non-intrusive instruction");

endmodule : sbt_tap
`default_nettype wire

// *** test/sbt_ctl_model.sv ***
// Board-level test controller model: drives the test clock, mode select and serial data.
`timescale 1ns/1ps
`default_nettype none
module sbt_ctl_model (
   input wire logic clk_sys_i,
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o,
   input wire logic tdo_i
);
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
   end
   // One test clock of 8 system clocks, entered on a system clock edge; the clock rests low between frames.
   // Mode and data change together with the falling edge, so both stand 4 clocks on either side of the rise.
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      tms_o <= tms;
      tdi_o <= tdi;
      repeat (4) @(posedge clk_sys_i);
      tdo = tdo_i;
      tck_o <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      tck_o <= 1'b0;
   endtask : step
   task automatic walk(input logic [7:0] seq, input int n);
      logic d;
      for (int i = 0; i < n; i++) begin
         step(seq[i], 1'b0, d);
      end
   endtask : walk
   task automatic shift(input int n, input logic [108:0] din, output logic [108:0] dout);
      dout = '0;
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], dout[i]);
      end
   endtask : shift
   task automatic reset_tap();
      walk(8'h1f, 6);
   endtask : reset_tap
   task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
      logic [108:0] o;
      logic [2:0] c;
      // Reserved codes are never put on the wire; bypass goes out instead.
      c = (code inside {3'h3, 3'h5, 3'h6}) ? 3'h7 : code;
      walk(8'h03, 4);
      shift(3, {106'h0, c}, o);
      cap = o[2:0];
      walk(8'h01, 2);
   endtask : load_ir
   task automatic scan_dr(input int n, input logic [108:0] din, output logic [108:0] dout);
      walk(8'h01, 3);
      shift(n, din, dout);
      walk(8'h01, 2);
   endtask : scan_dr
endmodule : sbt_ctl_model
`default_nettype wire

// *** test/sbt_tap_test.sv ***
// Self-checking bench for the boundary-scan access port.
`timescale 1ns/1ps
`default_nettype none
module sbt_tap_test;
   import sbt_pkg::*;
   localparam logic [RING_LEN-1:0] RING_A = {27{4'h9}};
   localparam logic [BSR_LEN-1:0] PRE_A = {1'b0, {27{4'hc}}};
   logic clk_sys_i, resetn_i, tck, tms, tdi, tdo, tdo_oe_n, extest, q_oe_n;
   logic [RING_LEN-1:0] ring_in, ring_out;
   logic [BSR_LEN-1:0] so;
   logic [2:0] cap;
   int bad_count, checks;
   sbt_tap sbt_tap_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
      .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n), .ring_in_i(ring_in), .ring_out_o(ring_out), .extest_o(extest),
      .q_oe_n_o(q_oe_n));
   sbt_ctl_model sbt_ctl_model_inst (.clk_sys_i(clk_sys_i), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   task automatic chk(input string name, input logic [108:0] seen, input logic [108:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out
   task automatic outs(input logic ext, input logic oen);
      chk("extest", 109'(extest), 109'(ext));
      chk("q_oe_n", 109'(q_oe_n), 109'(oen));
      chk("tdo_oe_n", 109'(tdo_oe_n), 109'h1);
   endtask : outs
   task automatic t_id();
      sbt_ctl_model_inst.scan_dr(32, '0, so);
      chk("id word", 109'(so[31:0]), 109'(ID_VALUE));
      chk("id presence", 109'(so[0]), 109'h1);
      outs(1'b0, 1'b0);
   endtask : t_id
   task automatic t_bypass();
      sbt_ctl_model_inst.load_ir(IR_BYPASS, cap);
      chk("ir capture", 109'(cap), 109'(IR_CAPTURE));
      sbt_ctl_model_inst.scan_dr(8, 109'h5a, so);
      chk("bypass", 109'(so[7:0]), 109'({7'h5a, BYPASS_CAPTURE}));
      outs(1'b0, 1'b0);
   endtask : t_bypass
   task automatic t_preload();
      sbt_ctl_model_inst.load_ir(IR_PRELOAD, cap);
      sbt_ctl_model_inst.scan_dr(109, PRE_A, so);
      chk("preload cap", so, {CTRL_CELL_RESET, RING_A});
      chk("preload upd", 109'(ring_out), 109'(PRE_A[107:0]));
      outs(1'b0, 1'b0);
   endtask : t_preload
   task automatic t_extest();
      sbt_ctl_model_inst.load_ir(IR_EXTEST, cap);
      outs(1'b1, 1'b1);
      chk("extest pins", 109'(ring_out), 109'(PRE_A[107:0]));
      sbt_ctl_model_inst.scan_dr(109, {1'b1, RING_A}, so);
      chk("extest cap", so, {1'b0, RING_A});
      chk("extest upd", 109'(ring_out), 109'(RING_A));
      outs(1'b1, 1'b0);
   endtask : t_extest
   task automatic t_samplez();
      sbt_ctl_model_inst.load_ir(IR_SAMPLEZ, cap);
      outs(1'b0, 1'b1);
      sbt_ctl_model_inst.scan_dr(109, PRE_A, so);
      chk("samplez cap", so, {1'b1, RING_A});
      outs(1'b0, 1'b1);
      sbt_ctl_model_inst.load_ir(IR_IDCODE, cap);
      outs(1'b0, 1'b0);
   endtask : t_samplez
   task automatic t_tlr();
      // Cell 108 was cleared by the last chain scan, so extest floats the outputs.
      sbt_ctl_model_inst.load_ir(IR_EXTEST, cap);
      outs(1'b1, 1'b1);
      sbt_ctl_model_inst.reset_tap();
      outs(1'b0, 1'b0);
      t_id();
      sbt_ctl_model_inst.load_ir(IR_EXTEST, cap);
      outs(1'b1, 1'b0);
   endtask : t_tlr
   task automatic t_reset();
      // Cell 108 is cleared first so that the preset by a mid-run reset can be seen.
      sbt_ctl_model_inst.scan_dr(109, {1'b0, RING_A}, so);
      chk("extest recap", so, {CTRL_CELL_RESET, RING_A});
      outs(1'b1, 1'b1);
      resetn_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      @(posedge clk_sys_i);
      outs(1'b0, 1'b0);
      chk("ring after reset", 109'(ring_out), 109'h0);
      sbt_ctl_model_inst.walk(8'h00, 1);
      sbt_ctl_model_inst.load_ir(IR_EXTEST, cap);
      outs(1'b1, 1'b0);
   endtask : t_reset
   initial begin
      resetn_i = 1'b0;
      ring_in = '0;
      bad_count = 0;
      checks = 0;
      repeat (10) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      ring_in <= RING_A;
      @(posedge clk_sys_i);
      outs(1'b0, 1'b0);
      sbt_ctl_model_inst.walk(8'h00, 1);
      t_id();
      t_bypass();
      t_preload();
      t_extest();
      t_samplez();
      t_tlr();
      t_reset();
      close_out();
   end
   initial begin
      repeat (100000) @(posedge clk_sys_i);
      bad_count++;
      close_out();
   end
endmodule : sbt_tap_test
`default_nettype wire
